// ### rss_cfg.svh
/*
  Constants of the reset strap sampler: register offsets, status bit
  positions, reset values and timing counts.
  Assumes it is included by bare name from every file that needs it.
*/
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ==========================================================
// Register byte offsets (one 32-bit word each)
`define RSS_OFS_STATUS 5'h00
`define RSS_OFS_MASK 5'h04
`define RSS_OFS_STRAP 5'h08
`define RSS_OFS_STATE 5'h0C

// ==========================================================
// Status and mask bit positions
`define RSS_ST_MCHECK 0
`define RSS_ST_TAPRST 1
`define RSS_ST_CAPTURE 2
`define RSS_ST_W 3

// ==========================================================
// Reset values
`define RSS_STATUS_RST 3'h0
`define RSS_MASK_RST 3'h0
`define RSS_STRAP_RST 8'hFF
`define RSS_NOPULL_MASK 8'h03

// ==========================================================
// Strap width and timing counts
`define RSS_STRAP_W 8
`define RSS_PU_HOLD_CYC 4
`define RSS_TMS_RESET_CNT 5

`endif

// ### rss_pkg.sv
/*
  Types of the reset strap sampler.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rss_pkg;

  // ==========================================================
  // Pin phase, Gray coded along sample -> settle -> functional
  typedef enum logic [1:0] {
    PH_SAMPLE = 2'h0,
    PH_SETTLE = 2'h1,
    PH_FUNC = 2'h3
  } rss_phase_t;

endpackage

// ### rss_sync.sv
/*
  Two-flop synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level; no bundle coherence is promised.
*/
module rss_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_ref_clk, // Block clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [W-1:0] i_d, // Asynchronous levels
  output logic [W-1:0] o_q // Synchronised levels
);

  logic [W-1:0] meta;

  // ==========================================================
  // First stage feeds only the second stage
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= RST_VAL;
      o_q <= RST_VAL;
    end
    else
    begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule // rss_sync

// ### rss_tap.sv
/*
  Test access port reset detector: sees the test reset pin and a run of
  mode-select highs on test clock rising edges.
  Assumes the test clock is far slower than the block clock.
*/
`include "rss_cfg.svh"

module rss_tap (
  input wire logic i_ref_clk, // Block clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_tck, // Test clock pin
  input wire logic i_tms, // Test mode select pin
  input wire logic i_trst_n, // Test reset pin, active low
  output logic o_tap_reset, // TAP held in reset
  output logic o_tms_evt // Pulse: reset reached through mode select
);

  logic [2:0] pins_s;
  logic tck_s, tms_s, trst_s, tck_d, tck_rise;
  logic [2:0] cnt;

  // ==========================================================
  // Pin synchronisers, test reset comes up asserted
  rss_sync #(.W(3), .RST_VAL(3'h0)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_tck, i_tms, i_trst_n}),
    .o_q(pins_s)
  );
  assign {tck_s, tms_s, trst_s} = pins_s;
  assign tck_rise = tck_s && !tck_d;

  // Edge history of the synchronised test clock
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tck_d <= 1'b0;
    else
      tck_d <= tck_s;
  end

  // Count consecutive high mode-select samples, saturating
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt <= 3'h0;
    else if (tck_rise)
      cnt <= !tms_s ? 3'h0 : (cnt == 3'(`RSS_TMS_RESET_CNT)) ? cnt : cnt + 3'h1;
  end

  // Reset by test reset pin or by five mode-select highs
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tap_reset <= 1'b1;
      o_tms_evt <= 1'b0;
    end
    else
    begin
      o_tms_evt <= tck_rise && tms_s && cnt == 3'(`RSS_TMS_RESET_CNT - 1);
      o_tap_reset <= !trst_s || (tck_rise && tms_s && cnt >= 3'(`RSS_TMS_RESET_CNT - 1))
        || (o_tap_reset && !(tck_rise && !tms_s));
    end
  end

  // ==========================================================
  // Checks
  chk_tms_run_reset: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (tck_rise && tms_s && cnt == 3'h4) |=> (o_tap_reset && o_tms_evt))
    else $error("TAP reset missing after five mode-select highs");
  chk_trst_forces: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !trst_s |=> o_tap_reset)
    else $error("TAP not in reset while test reset is low");

endmodule // rss_tap

// ### rss_top.sv
/*
  Reset strap sampler: catches power-on configuration from multiplexed
  strap pins at the release of hard reset, then hands the pins back to
  their functional output role; turns soft reset into a machine-check
  request; detects TAP reset; Avalon-MM register slave with interrupt.
  Assumes hard reset, soft reset, straps and test pins are asynchronous
  board levels, and functional output data comes from this clock domain.
*/
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
// Operation
// - while hard reset is low, strap pins are inputs and never driven
// - strap levels are caught when hard reset releases and kept as configuration
// - after capture, receiver off and pin returns to its functional output
// - pull-ups on only in reset plus a few clocks, off with receiver
// - a sampled high level selects the default setting of each bit
// - clock-ratio straps get no internal pull-up
// - TAP reset also reachable with test clock and mode select alone
// - soft reset assertion raises a machine-check request to the core
`include "rss_cfg.svh"

module rss_top #(
  parameter int N_STRAP = `RSS_STRAP_W,
  parameter int PU_HOLD = `RSS_PU_HOLD_CYC,
  parameter logic [N_STRAP-1:0] NOPULL = `RSS_NOPULL_MASK
) (
  input wire logic i_ref_clk, // 40 MHz block clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_hard_reset_n, // Hard reset pin, active low
  input wire logic i_soft_reset_n, // Soft reset pin, active low
  input wire logic [N_STRAP-1:0] i_strap_pin, // Strap pin input level
  input wire logic [N_STRAP-1:0] i_func_out, // Functional output data
  output logic [N_STRAP-1:0] o_strap_pin_out, // Strap pin output level
  output logic o_strap_pin_oe_n, // Strap pin drive, active low
  output logic [N_STRAP-1:0] o_strap_pu_en, // Gated pull-up enables
  output logic o_strap_rx_en, // Input receiver enable
  output logic [N_STRAP-1:0] o_strap_cfg, // Captured configuration
  output rss_pkg::rss_phase_t o_pin_phase, // Pin phase
  output logic o_mcheck, // Machine-check request pulse
  input wire logic i_tck, // Test clock pin
  input wire logic i_tms, // Test mode select pin
  input wire logic i_trst_n, // Test reset pin, active low
  output logic o_tap_reset, // TAP held in reset
  input wire logic [4:0] i_avs_address, // Byte address
  input wire logic i_avs_read, // Read request
  input wire logic i_avs_write, // Write request
  input wire logic [31:0] i_avs_writedata, // Write data
  input wire logic [3:0] i_avs_byteenable, // Byte lanes
  output logic [31:0] o_avs_readdata, // Read data
  output logic o_avs_waitrequest, // Wait, active high
  output logic o_irq // Level interrupt
);
  import rss_pkg::*;

  // ==========================================================
  // Declarations
  logic [N_STRAP+1:0] pins_s;
  logic [N_STRAP-1:0] strap_s;
  logic hr_n_s, sr_n_s, sr_d;
  logic mc_evt, cap_evt, tms_evt;
  rss_phase_t phase, next_phase;
  logic [7:0] hold_cnt;
  logic [`RSS_ST_W-1:0] status, next_status, mask, next_mask, st_clr;
  logic [31:0] rd_mux;
  logic acc_rd, acc_wr;

  // ==========================================================
  // Pin synchronisers; hard reset comes up asserted, straps at default
  rss_sync #(
    .W(N_STRAP + 2),
    .RST_VAL({1'b1, 1'b0, {N_STRAP{1'b1}}})
  ) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_soft_reset_n, i_hard_reset_n, i_strap_pin}),
    .o_q(pins_s)
  );
  assign {sr_n_s, hr_n_s, strap_s} = pins_s;

  // ==========================================================
  // Pin phase
  // Any return of hard reset restarts sampling, even mid-settle
  always_comb
  begin
    next_phase = phase;
    case (phase)
      PH_SAMPLE:
        if (hr_n_s)
          next_phase = PH_SETTLE;
      PH_SETTLE:
        if (!hr_n_s)
          next_phase = PH_SAMPLE;
        else if (hold_cnt == 8'(PU_HOLD - 1))
          next_phase = PH_FUNC;
      PH_FUNC:
        if (!hr_n_s)
          next_phase = PH_SAMPLE;
      default:
        next_phase = PH_SAMPLE;
    endcase
  end

  // Phase register
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      phase <= PH_SAMPLE;
    else
      phase <= next_phase;
  end

  // Settle counter keeps the pull-up on a few clocks past release
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      hold_cnt <= 8'h00;
    else if (phase == PH_SETTLE && hr_n_s)
      hold_cnt <= hold_cnt + 8'h01;
    else
      hold_cnt <= 8'h00;
  end

  // ==========================================================
  // Capture
  // Caught only on the release edge, so later pin traffic is ignored
  assign cap_evt = (phase == PH_SAMPLE) && hr_n_s;

  // Captured configuration; high means default, so reset shows defaults
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_strap_cfg <= `RSS_STRAP_RST;
    else if (cap_evt)
      o_strap_cfg <= strap_s;
  end

  // ==========================================================
  // Pad control, registered from the next phase
  // Receiver and pull-up drop in the same edge as the driver turns on
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_strap_pin_oe_n <= 1'b1;
      o_strap_rx_en <= 1'b1;
      o_strap_pu_en <= ~NOPULL;
      o_strap_pin_out <= '0;
      o_pin_phase <= PH_SAMPLE;
    end
    else
    begin
      o_strap_pin_oe_n <= (next_phase != PH_FUNC);
      o_strap_rx_en <= (next_phase != PH_FUNC);
      o_strap_pu_en <= (next_phase != PH_FUNC) ? ~NOPULL : '0;
      o_strap_pin_out <= (next_phase == PH_FUNC) ? i_func_out : '0;
      o_pin_phase <= next_phase;
    end
  end

  // ==========================================================
  // Soft reset to machine check
  // Edge, not level: a held soft reset asks the core only once
  assign mc_evt = sr_d && !sr_n_s;

  // Soft reset edge history and request pulse
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sr_d <= 1'b1;
      o_mcheck <= 1'b0;
    end
    else
    begin
      sr_d <= sr_n_s;
      o_mcheck <= mc_evt;
    end
  end

  // ==========================================================
  // TAP reset detector
  rss_tap u_tap (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_tck(i_tck),
    .i_tms(i_tms),
    .i_trst_n(i_trst_n),
    .o_tap_reset(o_tap_reset),
    .o_tms_evt(tms_evt)
  );

  // ==========================================================
  // Avalon-MM slave: one wait state on every access
  assign acc_rd = i_avs_read && !o_avs_waitrequest;
  assign acc_wr = i_avs_write && !o_avs_waitrequest;

  // Read mux; unmapped addresses read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      `RSS_OFS_STATUS: rd_mux = {29'h0, status};
      `RSS_OFS_MASK: rd_mux = {29'h0, mask};
      `RSS_OFS_STRAP: rd_mux = {{(32 - N_STRAP){1'b0}}, o_strap_cfg};
      `RSS_OFS_STATE: rd_mux = {28'h0, o_tap_reset, hr_n_s, o_pin_phase};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Wait state and read data; data stands through the accepting edge
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end
    else if ((i_avs_read || i_avs_write) && o_avs_waitrequest)
    begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= rd_mux;
    end
    else
      o_avs_waitrequest <= 1'b1;
  end

  // Next mask, low byte lane only; the interrupt uses it so it never lags a mask write
  assign next_mask = (acc_wr && i_avs_address == `RSS_OFS_MASK && i_avs_byteenable[0])
    ? i_avs_writedata[`RSS_ST_W-1:0] : mask;

  // Mask register
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      mask <= `RSS_MASK_RST;
    else
      mask <= next_mask;
  end

  // ==========================================================
  // Sticky status, cleared by read
  // Only bits that were returned are cleared, and a new event wins
  always_comb
  begin
    st_clr = '0;
    if (acc_rd && i_avs_address == `RSS_OFS_STATUS)
      st_clr = o_avs_readdata[`RSS_ST_W-1:0];
    next_status = status & ~st_clr;
    next_status[`RSS_ST_MCHECK] = next_status[`RSS_ST_MCHECK] | mc_evt;
    next_status[`RSS_ST_TAPRST] = next_status[`RSS_ST_TAPRST] | tms_evt;
    next_status[`RSS_ST_CAPTURE] = next_status[`RSS_ST_CAPTURE] | cap_evt;
  end

  // Status and interrupt registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      status <= `RSS_STATUS_RST;
      o_irq <= 1'b0;
    end
    else
    begin
      status <= next_status;
      o_irq <= |(next_status & next_mask);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_release;
    (phase == PH_SAMPLE) && hr_n_s;
  endsequence

  sequence s_settle_run;
    s_release ##1 hr_n_s [*4];
  endsequence

  chk_reset_no_drive: assert property (
    !hr_n_s |=> o_strap_pin_oe_n && o_strap_rx_en)
    else $error("Strap pin driven during hard reset");

  chk_capture_value: assert property (
    s_release |=> (o_strap_cfg == $past(strap_s)))
    else $error("Strap value not captured at release");

  chk_func_after_hold: assert property (
    s_settle_run |=> !o_strap_pin_oe_n && !o_strap_rx_en && o_pin_phase == PH_FUNC)
    else $error("Pin not returned to output after settle");

  chk_pullup_settle: assert property (
    s_settle_run |-> (o_strap_pu_en == ~NOPULL) ##1 (o_strap_pu_en == '0))
    else $error("Pull-up not held exactly through settle");

  chk_pullup_rx_tie: assert property (
    (o_strap_pu_en != '0) |-> o_strap_rx_en && o_strap_pin_oe_n)
    else $error("Pull-up on while receiver off or pin driven");

  chk_default_high: assert property (
    s_release and (strap_s == '1) |=> (o_strap_cfg == '1))
    else $error("High straps did not select defaults");

  chk_nopull_ratio: assert property (
    (o_strap_pu_en & NOPULL) == '0)
    else $error("Pull-up enabled on a clock-ratio strap");

  chk_cfg_stable: assert property (
    (phase != PH_SAMPLE) || !hr_n_s |=> $stable(o_strap_cfg))
    else $error("Configuration changed without a new release");

  chk_mcheck_pulse: assert property (
    $fell(sr_n_s) |=> o_mcheck ##1 (!o_mcheck && status[`RSS_ST_MCHECK]))
    else $error("Soft reset did not raise one machine-check pulse");

  chk_irq_follow: assert property (
    o_irq == ((status & mask) != '0))
    else $error("Interrupt level differs from unmasked status");

endmodule // rss_top

// ### rss_board.sv
/*
  Board model beside the reset strap sampler: strap resistors on each pin.
  Assumes the sampler drives the pins only while its enable is low.
*/
module rss_board (
  input wire logic i_ref_clk, // Block clock, only paces the float pattern
  input wire logic [7:0] i_pd, // Board pull-down per pin
  input wire logic [7:0] i_up, // Board pull-up per pin
  input wire logic [7:0] i_pin_out, // Level driven by the sampler
  input wire logic i_oe_n, // Sampler drive, active low
  input wire logic [7:0] i_pu_en, // Gated internal pull-ups
  output logic [7:0] o_pin // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] flt = 8'h55;

  // =========================================================
  // Pin resolution
  // An undriven pin with no pull toggles, so a stale level never passes
  always @(posedge i_ref_clk)
  begin
    flt <= ~flt;
  end

  // Pull-down only for non-default choices; ratio straps get a board pull-up
  always_comb
  begin
    if (!i_oe_n)
      o_pin = i_pin_out;
    else
      o_pin = (~i_pd & (i_up | i_pu_en)) | (~i_pd & ~i_up & ~i_pu_en & flt);
  end
endmodule // rss_board

// ### tb_rss_top.sv
/*
  Self-checking bench of the reset strap sampler: strap capture, pin
  hand-back, soft reset, TAP reset and the register interface.
  Assumes the design defaults: eight straps, four settle clocks.
*/
`include "rss_cfg.svh"

module tb_rss_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rss_pkg::*;
  logic ref_clk, rst_n, hard_n, soft_n, tck, tms, trst_n, rd, wr;
  logic [7:0] pd, up, func, pin, pin_out, pu, cfg, ex;
  logic oe_n, rx_en, mcheck, tap_rst, wreq, irq;
  logic [3:0] be;
  rss_phase_t phase;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, v;
  int n_errors, checks, k, cnt;

  rss_top i_rss_top (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_hard_reset_n(hard_n),
    .i_soft_reset_n(soft_n), .i_strap_pin(pin), .i_func_out(func), .o_strap_pin_out(pin_out),
    .o_strap_pin_oe_n(oe_n), .o_strap_pu_en(pu), .o_strap_rx_en(rx_en), .o_strap_cfg(cfg),
    .o_pin_phase(phase), .o_mcheck(mcheck), .i_tck(tck), .i_tms(tms), .i_trst_n(trst_n),
    .o_tap_reset(tap_rst), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_irq(irq));

  rss_board i_rss_board (.i_ref_clk(ref_clk), .i_pd(pd), .i_up(up), .i_pin_out(pin_out),
    .i_oe_n(oe_n), .i_pu_en(pu), .o_pin(pin));

  // =========================================================
  // Helpers
  function automatic logic [7:0] exp_cfg(input logic [7:0] d, input logic [7:0] u);
    return ~d & (u | ~`RSS_NOPULL_MASK);
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      n_errors++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Request held until the edge that sees waitrequest low; data taken there
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge ref_clk);
      if (wreq === 1'b0)
        break;
    end
    v = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 20)
    begin
      chk("bus wait", 1, 0);
      report_and_stop;
    end
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input string name, input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(name, v, exp);
  endtask

  task automatic wait_ph(input rss_phase_t p);
    for (k = 0; k < 40 && phase !== p; k++)
      @(posedge ref_clk);
    if (phase !== p)
    begin
      chk("phase wait", phase, p);
      report_and_stop;
    end
  endtask

  // Test clock far slower than the block clock
  task automatic tck_pulse(input logic m);
    tms <= m;
    tick(4);
    tck <= 1'b1;
    tick(4);
    tck <= 1'b0;
  endtask

  // =========================================================
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // =========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    hard_n = 1'b0;
    soft_n = 1'b1;
    tck = 1'b0;
    tms = 1'b0;
    trst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    be = 4'hF;
    addr = 5'h00;
    wdata = 32'h0;
    func = 8'h3C;
    pd = 8'h5A;
    up = 8'h01;
    n_errors = 0;
    checks = 0;
    tick(2);
    rst_n <= 1'b1;
    tick(8);
    chk("oe_n in reset", oe_n, 1'b1);
    chk("pull-ups in reset", pu, 8'hFC);
    chk("rx_en in reset", rx_en, 1'b1);
    chk("tap in reset", tap_rst, 1'b1);
    rdchk("status", `RSS_OFS_STATUS, 32'h0);
    rdchk("mask", `RSS_OFS_MASK, 32'h0);
    rdchk("strap", `RSS_OFS_STRAP, 32'hFF);
    rdchk("state", `RSS_OFS_STATE, 32'h8);
    $display("test reset done");

    ex = exp_cfg(pd, up);
    hard_n <= 1'b1;
    wait_ph(PH_SETTLE);
    chk("pull-ups settle", pu, 8'hFC);
    chk("rx_en settle", rx_en, 1'b1);
    chk("oe_n settle", oe_n, 1'b1);
    wait_ph(PH_FUNC);
    chk("cfg", cfg, ex);
    chk("oe_n func", oe_n, 1'b0);
    chk("pull-ups func", pu, 8'h00);
    chk("rx_en func", rx_en, 1'b0);
    tick(2);
    chk("pin out", pin_out, 8'h3C);
    chk("pin level", pin, 8'h3C);
    rdchk("capture event", `RSS_OFS_STATUS, 32'h4);
    rdchk("status cleared", `RSS_OFS_STATUS, 32'h0);
    rdchk("strap reg", `RSS_OFS_STRAP, {24'h0, ex});
    rdchk("state func", `RSS_OFS_STATE, 32'hF);
    $display("test capture done");

    pd <= 8'hFF;
    func <= 8'hC3;
    tick(6);
    chk("cfg held", cfg, ex);
    chk("pin follows", pin, 8'hC3);
    bus(1'b1, `RSS_OFS_STRAP, 32'h0);
    rdchk("strap read only", `RSS_OFS_STRAP, {24'h0, ex});
    rdchk("unmapped", 5'h10, 32'h0);
    $display("test hold done");

    bus(1'b1, `RSS_OFS_MASK, 32'h1);
    rdchk("mask set", `RSS_OFS_MASK, 32'h1);
    // A mask write without its byte lane must leave the mask alone
    be <= 4'hE;
    bus(1'b1, `RSS_OFS_MASK, 32'h0);
    be <= 4'hF;
    rdchk("mask lane off", `RSS_OFS_MASK, 32'h1);
    soft_n <= 1'b0;
    cnt = 0;
    repeat (12)
    begin
      @(posedge ref_clk);
      if (mcheck === 1'b1)
        cnt++;
    end
    chk("mcheck pulses", cnt, 1);
    chk("irq raised", irq, 1'b1);
    rdchk("mcheck status", `RSS_OFS_STATUS, 32'h1);
    tick(2);
    chk("irq cleared", irq, 1'b0);
    soft_n <= 1'b1;
    $display("test soft reset done");

    trst_n <= 1'b1;
    tck_pulse(1'b0);
    tick(4);
    chk("tap released", tap_rst, 1'b0);
    repeat (4) tck_pulse(1'b1);
    tick(4);
    chk("tap after four", tap_rst, 1'b0);
    tck_pulse(1'b1);
    tick(4);
    chk("tap after five", tap_rst, 1'b1);
    chk("irq masked", irq, 1'b0);
    rdchk("tap status", `RSS_OFS_STATUS, 32'h2);
    tck_pulse(1'b0);
    tick(4);
    chk("tap released again", tap_rst, 1'b0);
    trst_n <= 1'b0;
    tick(4);
    chk("tap by test reset", tap_rst, 1'b1);
    $display("test tap done");

    hard_n <= 1'b0;
    pd <= 8'h81;
    up <= 8'h02;
    tick(5);
    chk("oe_n again", oe_n, 1'b1);
    chk("phase again", phase, PH_SAMPLE);
    chk("cfg until release", cfg, ex);
    ex = exp_cfg(8'h81, 8'h02);
    hard_n <= 1'b1;
    wait_ph(PH_FUNC);
    chk("cfg second", cfg, ex);
    // All straps high, ratio straps by board pull-up: every bit at default
    hard_n <= 1'b0;
    pd <= 8'h00;
    up <= 8'h03;
    tick(5);
    hard_n <= 1'b1;
    wait_ph(PH_FUNC);
    chk("cfg defaults", cfg, exp_cfg(8'h00, 8'h03));
    $display("test second capture done");
    report_and_stop;
  end
endmodule // tb_rss_top
